// *** hw/rpw_pkg.sv ***
// constants for the low-frequency periodic wakeup clock
// assumes an 8-bit special function register bus and a 32 kHz oscillator cell

package rpw_pkg;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [7:0] RPW_CLOCK_CONTROL_ADDR = 8'hAC;
  localparam logic [7:0] RPW_FREQUENCY_TRIM_ADDR = 8'hAD;
  localparam logic [7:0] RPW_CLOCK_CONTROL_RESET = 8'h00;
  localparam logic [7:0] RPW_FREQUENCY_TRIM_RESET = 8'h00;
  localparam logic [7:0] RPW_UNMAPPED_READ = 8'h00;

  // ---------------------------------------------------------------
  // control register fields
  // ---------------------------------------------------------------
  localparam int RPW_FACTORY_TEST_B_BIT = 7;
  localparam int RPW_FACTORY_TEST_A_BIT = 6;
  localparam int RPW_PIN_ENABLE_BIT = 5;
  localparam int RPW_RUN_BIT = 4;
  localparam int RPW_TICK_FLAG_BIT = 3;
  localparam int RPW_SELECT_HIGH_BIT = 1;
  localparam int RPW_SELECT_LOW_BIT = 0;

  // ---------------------------------------------------------------
  // period selection and divider figures
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    RPW_PERIOD_1S = 2'h0,
    RPW_PERIOD_2S = 2'h1,
    RPW_PERIOD_4S = 2'h2,
    RPW_PERIOD_1MIN = 2'h3
  } rpw_period_t;

  localparam int RPW_TICKS_PER_SECOND = 16384;
  localparam int RPW_SECONDS_PER_MINUTE = 60;
  localparam logic [1:0] RPW_QUAD_LAST_OF_TWO = 2'h1;
  localparam logic [1:0] RPW_QUAD_LAST_OF_FOUR = 2'h3;

endpackage

// *** hw/rpw_periodic_wakeup.sv ***
// periodic wakeup clock: 32 kHz divider, period flag, trim and pin mux
// assumes mclk stays on in idle and power-down; osc_32k comes from the
// oscillator cell asynchronously and the port block keeps the pin latch
`timescale 1ns/10ps

module rpw_periodic_wakeup #(
  parameter int TICKS_PER_SECOND = rpw_pkg::RPW_TICKS_PER_SECOND,
  parameter int SECONDS_PER_MINUTE = rpw_pkg::RPW_SECONDS_PER_MINUTE
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  output logic [7:0] sfr_rdata,
  input wire logic osc_32k,
  output logic osc_enable,
  output logic tick_irq,
  input wire logic port_latch,
  input wire logic pin_in,
  output logic pin_out,
  output logic pin_oe,
  output logic pin_level,
  output logic divided_16k_clock
);

  // ---------------------------------------------------------------
  // sizes and elaboration checks
  // ---------------------------------------------------------------
  localparam int SUBW = $clog2(TICKS_PER_SECOND);
  localparam logic [SUBW-1:0] SUB_LAST = SUBW'(TICKS_PER_SECOND - 1);
  localparam logic [5:0] SEC_LAST = 6'(SECONDS_PER_MINUTE - 1);

  if (TICKS_PER_SECOND < 2 || SECONDS_PER_MINUTE < 4 || SECONDS_PER_MINUTE > 64) begin : g_chk
    $error("rpw_periodic_wakeup: divider parameters out of range");
  end

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic osc_m;
    logic osc_q;
    logic osc_d;
    logic pin_m;
    logic pin_q;
    logic clk16;
    logic half;
    logic [7:0] dup;
    logic [SUBW-1:0] sub;
    logic [5:0] sec;
    logic [1:0] quad;
    logic test_b;
    logic test_a;
    logic pin_en;
    logic run;
    logic flag;
    rpw_pkg::rpw_period_t sel;
    logic [7:0] trim;
    logic [7:0] rdata;
    logic osc_en;
    logic p_out;
    logic p_oe;
  } rpw_state_t;

  rpw_state_t s;
  rpw_state_t next_s;

  // helpers kept as plain wires so the assertions can see them
  logic rise32;
  logic tick16;
  logic sec_evt;
  logic min_evt;
  logic period_evt;
  logic wr_ctl;
  logic wr_trim;

  // selected period ends on the last second of its group
  function automatic logic period_done(input rpw_pkg::rpw_period_t sel,
                                       input logic [1:0] quad,
                                       input logic last_sec);
    unique case (sel)
      rpw_pkg::RPW_PERIOD_1S: period_done = 1'b1;
      rpw_pkg::RPW_PERIOD_2S: period_done = quad[0] == rpw_pkg::RPW_QUAD_LAST_OF_TWO[0];
      rpw_pkg::RPW_PERIOD_4S: period_done = quad == rpw_pkg::RPW_QUAD_LAST_OF_FOUR;
      rpw_pkg::RPW_PERIOD_1MIN: period_done = last_sec;
    endcase
  endfunction

  // control register image as software sees it; bit 2 reads zero
  function automatic logic [7:0] ctl_image(input rpw_state_t st);
    ctl_image = 8'h00;
    ctl_image[rpw_pkg::RPW_FACTORY_TEST_B_BIT] = st.test_b;
    ctl_image[rpw_pkg::RPW_FACTORY_TEST_A_BIT] = st.test_a;
    ctl_image[rpw_pkg::RPW_PIN_ENABLE_BIT] = st.pin_en;
    ctl_image[rpw_pkg::RPW_RUN_BIT] = st.run;
    ctl_image[rpw_pkg::RPW_TICK_FLAG_BIT] = st.flag;
    ctl_image[rpw_pkg::RPW_SELECT_HIGH_BIT:rpw_pkg::RPW_SELECT_LOW_BIT] = st.sel;
  endfunction

  // ---------------------------------------------------------------
  // event decode
  // ---------------------------------------------------------------
  // edge detect reads only the second and third sync stages
  assign rise32 = s.osc_q & ~s.osc_d;
  // a 16 kHz period ends on the falling edge of the halved clock
  assign tick16 = rise32 & s.clk16 & s.run;
  // trim: the first trim ticks of second zero need two tick16 each
  // only second zero is ever stretched, so with 1 s ticks one interval
  // in each minute runs long and the others stay nominal
  assign sec_evt = tick16 & ~(s.sec == 6'h00 && s.dup < s.trim && !s.half)
                   & (s.sub == SUB_LAST);
  assign min_evt = sec_evt & (s.sec == SEC_LAST);
  assign period_evt = sec_evt & period_done(s.sel, s.quad, s.sec == SEC_LAST);
  assign wr_ctl = sfr_wr & (sfr_addr == rpw_pkg::RPW_CLOCK_CONTROL_ADDR);
  assign wr_trim = sfr_wr & (sfr_addr == rpw_pkg::RPW_FREQUENCY_TRIM_ADDR);

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  // no processor power state reaches this logic, so idle and power-down
  // leave it counting
  always_comb begin
    next_s = s;
    // synchronisers: three stages for the oscillator, two for the pin
    next_s.osc_m = osc_32k;
    next_s.osc_q = s.osc_m;
    next_s.osc_d = s.osc_q;
    next_s.pin_m = pin_in;
    next_s.pin_q = s.pin_m;

    // divider chain, held cleared while stopped
    if (!s.run) begin
      next_s.clk16 = 1'b0;
      next_s.half = 1'b0;
      next_s.dup = 8'h00;
      next_s.sub = '0;
      next_s.sec = 6'h00;
      next_s.quad = 2'h0;
    end else if (rise32) begin
      next_s.clk16 = ~s.clk16;
      if (tick16) begin
        // a zero trim never takes this branch, so no lengthening
        if (s.sec == 6'h00 && s.dup < s.trim && !s.half) begin
          next_s.half = 1'b1;
        end else begin
          next_s.half = 1'b0;
          if (s.half) begin
            next_s.dup = s.dup + 8'h01;
          end
          if (s.sub == SUB_LAST) begin
            next_s.sub = '0;
            next_s.quad = s.quad + 2'h1;
            if (s.sec == SEC_LAST) begin
              next_s.sec = 6'h00;
              next_s.dup = 8'h00;
            end else begin
              next_s.sec = s.sec + 6'h01;
            end
          end else begin
            next_s.sub = s.sub + SUBW'(1);
          end
        end
      end
    end

    // register writes; test bits are stored but steer nothing
    if (wr_ctl) begin
      next_s.test_b = sfr_wdata[rpw_pkg::RPW_FACTORY_TEST_B_BIT];
      next_s.test_a = sfr_wdata[rpw_pkg::RPW_FACTORY_TEST_A_BIT];
      next_s.pin_en = sfr_wdata[rpw_pkg::RPW_PIN_ENABLE_BIT];
      next_s.run = sfr_wdata[rpw_pkg::RPW_RUN_BIT];
      next_s.flag = sfr_wdata[rpw_pkg::RPW_TICK_FLAG_BIT];
      next_s.sel = rpw_pkg::rpw_period_t'(
        sfr_wdata[rpw_pkg::RPW_SELECT_HIGH_BIT:rpw_pkg::RPW_SELECT_LOW_BIT]);
    end
    if (wr_trim) begin
      next_s.trim = sfr_wdata;
    end
    // hardware set wins over a software clear in the same cycle
    if (period_evt) begin
      next_s.flag = 1'b1;
    end

    // read data, registered one cycle after the strobe
    if (sfr_rd) begin
      unique case (sfr_addr)
        rpw_pkg::RPW_CLOCK_CONTROL_ADDR: next_s.rdata = ctl_image(s);
        rpw_pkg::RPW_FREQUENCY_TRIM_ADDR: next_s.rdata = s.trim;
        default: next_s.rdata = rpw_pkg::RPW_UNMAPPED_READ;
      endcase
    end

    next_s.osc_en = next_s.run;
    // shared pin: driven clock when enabled, else quasi port drive of latch
    // the port latch gates the clock, so a cleared latch shows the conflict
    if (next_s.pin_en) begin
      next_s.p_out = next_s.clk16 & port_latch;
      next_s.p_oe = 1'b1;
    end else begin
      next_s.p_out = 1'b0;
      next_s.p_oe = ~port_latch;
    end
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (reset) begin
      s <= '{sel: rpw_pkg::RPW_PERIOD_1S, trim: rpw_pkg::RPW_FREQUENCY_TRIM_RESET,
             rdata: rpw_pkg::RPW_UNMAPPED_READ, default: '0};
    end else begin
      s <= next_s;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  // the flag is the level request and the wake source; nothing here
  // reaches the processor reset
  assign tick_irq = s.flag;
  assign sfr_rdata = s.rdata;
  assign osc_enable = s.osc_en;
  assign pin_out = s.p_out;
  assign pin_oe = s.p_oe;
  // pin reads stay live whatever the enable, latch is never touched here
  assign pin_level = s.pin_q;
  assign divided_16k_clock = s.clk16;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  flag_sticky_a: assert property (
    s.flag && !(wr_ctl && !sfr_wdata[rpw_pkg::RPW_TICK_FLAG_BIT]) |=> s.flag)
    else $error("tick flag dropped without a software clear");

  sw_clear_a: assert property (
    wr_ctl && !sfr_wdata[rpw_pkg::RPW_TICK_FLAG_BIT] && !period_evt |=> !tick_irq)
    else $error("software clear of tick flag ignored");

  hw_set_a: assert property (
    period_evt |=> tick_irq)
    else $error("period end did not raise the flag");

  stop_clear_a: assert property (
    !s.run |=> s.sub == '0 && s.sec == 6'h00 && !divided_16k_clock)
    else $error("divider not held while stopped");

  osc_follow_a: assert property (
    wr_ctl |=> osc_enable == $past(sfr_wdata[rpw_pkg::RPW_RUN_BIT]))
    else $error("oscillator enable does not follow run");

  minute_sel_a: assert property (
    period_evt && s.sel == rpw_pkg::RPW_PERIOD_1MIN |-> s.sec == SEC_LAST)
    else $error("minute tick away from the last second");

  four_sel_a: assert property (
    period_evt && s.sel == rpw_pkg::RPW_PERIOD_4S |=> s.quad == 2'h0)
    else $error("four second tick off its group");

  trim_zero_a: assert property (
    tick16 && s.trim == 8'h00 && s.sub != SUB_LAST |=> s.sub == $past(s.sub) + SUBW'(1))
    else $error("zero trim still stretched the second");

  trim_double_a: assert property (
    tick16 && s.sec == 6'h00 && s.dup < s.trim && !s.half |=> s.half && $stable(s.sub))
    else $error("trimmed tick was not counted twice");

  pin_drive_a: assert property (
    s.pin_en && port_latch && !wr_ctl |=> pin_oe && pin_out == s.clk16)
    else $error("16 kHz clock missing on enabled pin");

  read_trim_a: assert property (
    sfr_rd && sfr_addr == rpw_pkg::RPW_FREQUENCY_TRIM_ADDR && !wr_trim
      |=> sfr_rdata == $past(s.trim))
    else $error("trim register read back wrong");

  // divider corners that the period checks above do not pin down
  half_sec0_a: assert property (
    s.half |-> s.sec == 6'h00)
    else $error("trim doubling outside second zero");

  two_sel_a: assert property (
    period_evt && s.sel == rpw_pkg::RPW_PERIOD_2S |-> s.quad[0])
    else $error("two second tick off its group");

  stop_hold_a: assert property (
    !s.run |=> !s.half && s.dup == 8'h00 && s.quad == 2'h0)
    else $error("trim or group state kept while stopped");

  cov_second_c: cover property (period_evt && s.sel == rpw_pkg::RPW_PERIOD_1S);
  cov_minute_c: cover property (period_evt && s.sel == rpw_pkg::RPW_PERIOD_1MIN);
  cov_trim_c: cover property (s.half && tick16);
  cov_race_c: cover property (period_evt && wr_ctl);
  cov_pin_c: cover property (s.pin_en && tick16);

endmodule

// *** verif/rpw_osc_model.sv ***
// behavioural 32 kHz oscillator cell for the periodic wakeup clock
// assumes the design drives osc_enable from its run bit; the period is shortened for sim
`timescale 1ns/10ps

module rpw_osc_model #(
  parameter int HALF_NS = 250
) (
  input wire logic osc_enable,
  output logic osc_32k
);
  // ---------------------------------------------------------------
  // free time base, gated by the run enable
  // ---------------------------------------------------------------
  // a stopped cell rests low, never at its last level
  initial osc_32k = 1'b0;
  // edges on multiples of HALF_NS land on mclk falling edges, away from sampling
  always begin
    #HALF_NS;
    if (osc_enable === 1'b1) begin
      osc_32k = ~osc_32k;
    end else begin
      osc_32k = 1'b0;
    end
  end
endmodule

// *** verif/test_rpw_periodic_wakeup.sv ***
// bench for the periodic wakeup clock: registers, periods, trim, pin
// assumes rpw_pkg, the design and rpw_osc_model are compiled before it
`timescale 1ns/10ps

module test_rpw_periodic_wakeup;
  // ---------------------------------------------------------------
  // wiring
  // ---------------------------------------------------------------
  localparam int TPS = 8;
  localparam int SPM = 4;
  localparam int SEC = TPS * 2 * 20; // mclk per second: one tick is two osc rises
  logic mclk, reset, sfr_wr, sfr_rd, port_latch, ext_drive, pin_in;
  logic osc_32k, osc_enable, tick_irq, pin_out, pin_oe, pin_level, clk16;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, d, v;
  int errors = 0;
  int check_count = 0;
  int cyc = 0;
  int t0, t1, n, m, tr;
  // open-drain style pin: external side only shows when the block is off it
  assign pin_in = pin_oe ? pin_out : ext_drive;

  rpw_periodic_wakeup #(.TICKS_PER_SECOND(TPS), .SECONDS_PER_MINUTE(SPM)) dut (
    .mclk(mclk), .reset(reset), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .osc_32k(osc_32k),
    .osc_enable(osc_enable), .tick_irq(tick_irq), .port_latch(port_latch),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pin_level(pin_level),
    .divided_16k_clock(clk16));
  rpw_osc_model osc (.osc_enable(osc_enable), .osc_32k(osc_32k));

  // clock and cycle stamp
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  always @(posedge mclk) cyc <= cyc + 1;

  // ---------------------------------------------------------------
  // tasks and expectations
  // ---------------------------------------------------------------
  task automatic final_report();
    if (errors == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  task automatic chkr(input int got, input int lo, input int hi, input string what);
    check_count++;
    if (got < lo || got > hi) begin
      errors++;
      $display("Error at %0t: %s got %0d want %0d..%0d", $time, what, got, lo, hi);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] val);
    @(posedge mclk);
    #2;
    sfr_addr = a;
    sfr_wdata = val;
    sfr_wr = 1'b1;
    @(posedge mclk);
    #2;
    sfr_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] val);
    @(posedge mclk);
    #2;
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(posedge mclk);
    #2;
    sfr_rd = 1'b0;
    val = sfr_rdata;
  endtask
  // wait for the flag, stamp it, then clear it with ctl (bit 3 low)
  task automatic next_tick(input logic [7:0] ctl, output int t);
    int k;
    k = 0;
    while (tick_irq !== 1'b1 && k < 9000) begin
      @(posedge mclk);
      #1;
      k++;
    end
    t = cyc;
    chkr(k, 0, 8999, "tick wait");
    wr(8'hAC, ctl);
  endtask
  function automatic int sel_len(input int sel, input int trim);
    return (sel == 3 ? SPM : (1 << sel)) * SEC + trim * 40;
  endfunction

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    reset = 1'b1;
    sfr_addr = 8'h00;
    sfr_wdata = 8'h00;
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
    port_latch = 1'b1;
    ext_drive = 1'b1;
    d = 8'($urandom(32'hBA4E2229));
    repeat (20) @(posedge mclk);
    #2;
    reset = 1'b0;
    rd(8'hAC, v);
    chk8(v, 8'h00, "control after reset");
    rd(8'hAD, v);
    chk8(v, 8'h00, "trim after reset");
    // random register traffic; test bits kept at 0, bit 2 tried and read as 0
    repeat (6) begin
      d = 8'($urandom);
      wr(8'hAD, d);
      rd(8'hAD, v);
      chk8(v, d, "trim readback");
      d = 8'($urandom) & 8'h27;
      wr(8'hAC, d);
      rd(8'hAC, v);
      chk8(v, d & 8'h23, "control readback");
    end
    wr(8'hAE, 8'hFF);
    rd(8'hAE, v);
    chk8(v, 8'h00, "unmapped read");
    rd(8'hAC, v);
    chk8(v, d & 8'h23, "unmapped write ignored");
    // software set holds as a level until software clears
    wr(8'hAC, 8'h08);
    repeat (50) @(posedge mclk);
    chk8({7'h00, tick_irq}, 8'h01, "flag set by write");
    wr(8'hAC, 8'h00);
    chk8({7'h00, tick_irq}, 8'h00, "flag cleared by write");
    wr(8'hAD, 8'h00);
    // each period, restarted after a mid-period stop
    for (int s = 0; s < 4; s++) begin
      wr(8'hAC, 8'h10 | 8'(s));
      t0 = cyc;
      next_tick(8'h10 | 8'(s), t1);
      chkr(t1 - t0, sel_len(s, 0) - 20, sel_len(s, 0) + 10, "first period");
      next_tick(8'h10 | 8'(s), t0);
      chkr(t0 - t1, sel_len(s, 0) - 2, sel_len(s, 0) + 2, "period length");
      repeat (150) @(posedge mclk);
      wr(8'hAC, 8'h00);
      repeat (60) @(posedge mclk);
      chk8({6'h00, osc_enable, clk16}, 8'h00, "stopped divider");
    end
    // trimmed minute, then trimmed seconds
    // second zero holds only TPS ticks, so a larger trim could not all be doubled
    tr = 1 + ($urandom % TPS);
    wr(8'hAD, 8'(tr));
    wr(8'hAC, 8'h13);
    next_tick(8'h13, t0);
    next_tick(8'h13, t1);
    chkr(t1 - t0, sel_len(3, tr) - 2, sel_len(3, tr) + 2, "trimmed minute");
    wr(8'hAC, 8'h00);
    wr(8'hAC, 8'h10);
    next_tick(8'h10, t0);
    n = 0;
    repeat (8) begin
      next_tick(8'h10, t1);
      if (t1 - t0 > sel_len(0, 0) + 2) begin
        n++;
        chkr(t1 - t0, sel_len(0, tr) - 2, sel_len(0, tr) + 2, "long second");
      end else begin
        chkr(t1 - t0, sel_len(0, 0) - 2, sel_len(0, 0) + 2, "plain second");
      end
      t0 = t1;
    end
    chkr(n, 8 / SPM, 8 / SPM, "long second count");
    // clock on the pin, latch kept at 1: one rise per 40 mclk, pin still readable
    wr(8'hAC, 8'h30);
    n = 0;
    m = 0;
    repeat (400) begin
      d[0] = pin_out;
      d[1] = pin_level;
      @(posedge mclk);
      #1;
      if (pin_out === 1'b1 && d[0] === 1'b0) n++;
      if (pin_level === 1'b1 && d[1] === 1'b0) m++;
    end
    chkr(n, 9, 11, "pin clock rises");
    chkr(m, 9, 11, "pin level rises");
    chk8({7'h00, pin_out}, {7'h00, clk16}, "pin follows divider");
    chk8({7'h00, pin_oe}, 8'h01, "pin driven");
    // plain port line: latch drives low only, pin level still readable
    wr(8'hAC, 8'h10);
    repeat (10) begin
      @(posedge mclk);
      #2;
      port_latch = 1'($urandom);
      ext_drive = 1'($urandom);
      repeat (4) @(posedge mclk);
      #1;
      chk8({5'h00, pin_out, pin_oe, pin_level}, {6'h00, ~port_latch, pin_in},
           "port line");
    end
    // reset in mid-run clears the registers and stops the divider
    @(posedge mclk);
    #2;
    reset = 1'b1;
    repeat (3) @(posedge mclk);
    #2;
    reset = 1'b0;
    chk8({6'h00, osc_enable, tick_irq}, 8'h00, "stopped by reset");
    rd(8'hAC, v);
    chk8(v, 8'h00, "control after second reset");
    rd(8'hAD, v);
    chk8(v, 8'h00, "trim after second reset");
    final_report();
  end

  // watchdog against a hang
  initial begin
    repeat (40000) @(posedge mclk);
    errors++;
    final_report();
  end
endmodule
